// ---- design/sbl_counter.sv ----
// internal counter used for stop recovery and reset pin sampling
// assumes a synchronous clear that wins over counting
`timescale 1ns/1ps
module sbl_counter (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // control
  input wire logic hold,
  input wire logic [sbl_pkg::SBL_CNT_W-1:0] limit,
  // status
  output logic done,
  output logic [sbl_pkg::SBL_CNT_W-1:0] count
);
  import sbl_pkg::*;
  logic [SBL_CNT_W-1:0] cnt_r;
  always_ff @(posedge clk) begin
    if (srst || hold) begin
      cnt_r <= '0;
    end else if (cnt_r != limit) begin
      cnt_r <= cnt_r + 13'h0001;
    end
  end
  assign done = !hold && (cnt_r == limit);
  assign count = cnt_r;
endmodule : sbl_counter

// ---- design/sbl_pkg.sv ----
// constants, register map and types of the system integration unit
// assumes a single 10 MHz clock and a plain register port
// What this block does
// - all reset sources or-ed, power-on flag overrides the rest
// - break request forces software interrupt vector
// - break blocks flag clears unless enabled
// - flags cleared in break stay cleared
// - two-step clears protected across break entry
// - wait or stop clears interrupt mask
// - wait stops cpu clock, peripherals run
// - wait wake stacks one cycle later
// - reset or break exits wait, only break sets flag
// - watchdog runs in wait unless disabled
// - stop resets counter, gates both clocks
// - interrupt ends stop after recovery, reset ends it at once
// - recovery 4096 cycles, or 32 if short
// - counter held until recovery, then counts
// - reset cause register cleared by read
// - power-on sets its flag, clears others
// - drive reset pin low, sample 32 later
// - distinct flag for each reset cause
// - break-exited-wait flag reads one after break
package sbl_pkg;
  localparam logic [15:0] SBL_ADDR_BREAK_STATUS = 16'hFE00;
  localparam logic [15:0] SBL_ADDR_RESET_CAUSE = 16'hFE01;
  localparam logic [15:0] SBL_ADDR_BREAK_FLAG_CTRL = 16'hFE03;
  localparam int SBL_BIT_EXITED_WAIT = 1;
  localparam int SBL_BIT_CLEAR_ENABLE = 7;
  // reset cause bit positions
  localparam int SBL_BIT_LOW_VOLT = 1;
  localparam int SBL_BIT_MONITOR = 2;
  localparam int SBL_BIT_ILL_ADDR = 3;
  localparam int SBL_BIT_ILL_OP = 4;
  localparam int SBL_BIT_WATCHDOG = 5;
  localparam int SBL_BIT_PIN = 6;
  localparam int SBL_BIT_POWER_ON = 7;
  localparam logic [7:0] SBL_RESET_CAUSE_RST = 8'h80;
  localparam logic [7:0] SBL_BREAK_STATUS_RST = 8'h00;
  localparam logic [7:0] SBL_BREAK_FLAG_RST = 8'h00;
  localparam logic [15:0] SBL_SWI_VECTOR = 16'hFFFC;
  // timing
  localparam int SBL_CLK_HZ = 10_000_000;
  localparam int SBL_LONG_RECOVERY_CYC = 4096;
  localparam int SBL_SHORT_RECOVERY_CYC = 32;
  localparam int SBL_PIN_SAMPLE_CYC = 32;
  localparam int SBL_INT_RST_HOLD_CYC = 4;
  localparam int SBL_CNT_W = 13;
  typedef enum logic [2:0] {
    SBL_RUN, SBL_WAIT, SBL_STOP, SBL_RECOVER, SBL_STACK
  } sbl_mode_t;
endpackage : sbl_pkg

// ---- design/sbl_system_integration_unit.sv ----
// break, low-power sequencing and reset cause logic
// assumes cpu decodes wait/stop and peripherals honour flag_clear_ok
`timescale 1ns/1ps
module sbl_system_integration_unit (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // reset causes, pulses, any may coincide
  input wire logic power_on_rst,
  input wire logic watchdog_rst,
  input wire logic illegal_op_rst,
  input wire logic illegal_addr_rst,
  input wire logic monitor_rst,
  input wire logic low_volt_rst,
  // reset pin, open drain
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  output logic sys_reset,
  // cpu side
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic irq_pending,
  input wire logic break_req,
  output logic clear_int_mask,
  output logic force_vector,
  output logic [15:0] vector_addr,
  output logic stack_start,
  output logic in_break,
  input wire logic break_done,
  // configuration
  input wire logic short_stop_recovery,
  input wire logic watchdog_disable,
  input wire logic oscillator_on_in_stop,
  // clock gating and flag clear permission
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic osc_clk_en,
  output logic watchdog_run,
  output logic flag_clear_ok,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import sbl_pkg::*;

  sbl_mode_t mode_r;
  logic [7:0] cause_r;
  logic exited_wait_r;
  logic clear_enable_r;
  logic break_r;
  logic [7:0] rdata_r;
  logic [2:0] hold_r;
  logic pin_wait_r;
  logic any_int_rst;
  logic any_rst;
  logic cnt_hold;
  logic cnt_done;
  logic [SBL_CNT_W-1:0] cnt_limit;
  logic [SBL_CNT_W-1:0] cnt_val;
  logic cause_rd;

  // every source just or-ed into reset, but only power-on or srst clears the other cause flags
  assign any_int_rst = power_on_rst | watchdog_rst | illegal_op_rst | illegal_addr_rst
    | monitor_rst | low_volt_rst;
  assign any_rst = srst | any_int_rst | !rst_pin_in;
  assign cause_rd = reg_rd && (reg_addr == SBL_ADDR_RESET_CAUSE);

  // low-power and stop recovery sequencer
  always_ff @(posedge clk) begin
    if (any_rst) begin
      mode_r <= SBL_RUN;
    end else begin
      unique case (mode_r)
        SBL_RUN: begin
          if (stop_exec) begin
            mode_r <= SBL_STOP;
          end else if (wait_exec) begin
            mode_r <= SBL_WAIT;
          end
        end
        SBL_WAIT: begin
          if (break_req) begin
            mode_r <= SBL_RUN;
          end else if (irq_pending) begin
            mode_r <= SBL_STACK;
          end
        end
        SBL_STOP: begin
          if (irq_pending) begin
            mode_r <= SBL_RECOVER;
          end
        end
        SBL_RECOVER: begin
          if (cnt_done) begin
            mode_r <= SBL_STACK;
          end
        end
        SBL_STACK: begin
          mode_r <= SBL_RUN;
        end
      endcase
    end
  end

  assign stack_start = (mode_r == SBL_STACK);
  assign clear_int_mask = (mode_r == SBL_RUN) && (wait_exec || stop_exec);
  assign cpu_clk_en = (mode_r == SBL_RUN) || (mode_r == SBL_STACK);
  assign periph_clk_en = (mode_r != SBL_STOP) && (mode_r != SBL_RECOVER);
  assign osc_clk_en = (mode_r != SBL_STOP) || oscillator_on_in_stop;
  assign watchdog_run = !watchdog_disable && periph_clk_en;

  // counter held through stop, then times recovery or the pin sample
  assign cnt_hold = (mode_r == SBL_STOP) || (mode_r == SBL_RUN && (!pin_wait_r || hold_r != 3'h0)) || srst
    || any_int_rst;
  assign cnt_limit = (mode_r == SBL_RECOVER)
    ? (short_stop_recovery ? SBL_CNT_W'(SBL_SHORT_RECOVERY_CYC - 1)
                           : SBL_CNT_W'(SBL_LONG_RECOVERY_CYC - 1))
    : SBL_CNT_W'(SBL_PIN_SAMPLE_CYC - 1);

  sbl_counter u_cnt (
    .clk(clk),
    .srst(srst),
    .hold(cnt_hold),
    .limit(cnt_limit),
    .done(cnt_done),
    .count(cnt_val)
  );

  // reset pin driven low during internal reset, stretched a little
  always_ff @(posedge clk) begin
    if (srst || any_int_rst) begin
      hold_r <= 3'(SBL_INT_RST_HOLD_CYC);
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end
  assign rst_pin_oe = (hold_r != 3'h0);
  assign rst_pin_out = 1'b0;
  assign sys_reset = any_rst || (hold_r != 3'h0);

  // after release, wait to sample the pin
  always_ff @(posedge clk) begin
    if (srst || any_int_rst) begin
      pin_wait_r <= 1'b1;
    end else if (hold_r == 3'h0 && cnt_done && mode_r == SBL_RUN) begin
      pin_wait_r <= 1'b0;
    end
  end

  // reset cause flags, new causes win over read clear
  always_ff @(posedge clk) begin
    if (srst || power_on_rst) begin
      cause_r <= SBL_RESET_CAUSE_RST;
    end else begin
      cause_r <= cause_rd ? 8'h00 : cause_r;
      if (watchdog_rst) begin
        cause_r[SBL_BIT_WATCHDOG] <= 1'b1;
      end
      if (illegal_op_rst) begin
        cause_r[SBL_BIT_ILL_OP] <= 1'b1;
      end
      if (illegal_addr_rst) begin
        cause_r[SBL_BIT_ILL_ADDR] <= 1'b1;
      end
      if (monitor_rst) begin
        cause_r[SBL_BIT_MONITOR] <= 1'b1;
      end
      if (low_volt_rst) begin
        cause_r[SBL_BIT_LOW_VOLT] <= 1'b1;
      end
      if (pin_wait_r && hold_r == 3'h0 && cnt_done && mode_r == SBL_RUN && !rst_pin_in) begin
        cause_r[SBL_BIT_PIN] <= 1'b1;
      end else if (!rst_pin_in && hold_r == 3'h0 && !pin_wait_r) begin
        cause_r[SBL_BIT_PIN] <= 1'b1;
      end
    end
  end

  // break state
  always_ff @(posedge clk) begin
    if (any_rst) begin
      break_r <= 1'b0;
    end else if (break_req) begin
      break_r <= 1'b1;
    end else if (break_done) begin
      break_r <= 1'b0;
    end
  end
  assign in_break = break_r;
  assign force_vector = break_req && !break_r;
  assign vector_addr = SBL_SWI_VECTOR;

  // permission held low in break unless clear enable is set, so peripherals keep flags and
  // pending second steps, and never restore a cleared flag
  assign flag_clear_ok = !break_r || clear_enable_r;

  // break exited wait flag, set wins over write clear
  always_ff @(posedge clk) begin
    if (any_rst) begin
      exited_wait_r <= SBL_BREAK_STATUS_RST[SBL_BIT_EXITED_WAIT];
    end else if (mode_r == SBL_WAIT && break_req) begin
      exited_wait_r <= 1'b1;
    end else if (reg_wr && reg_addr == SBL_ADDR_BREAK_STATUS) begin
      exited_wait_r <= reg_wdata[SBL_BIT_EXITED_WAIT];
    end
  end

  // break clear enable
  always_ff @(posedge clk) begin
    if (any_rst) begin
      clear_enable_r <= SBL_BREAK_FLAG_RST[SBL_BIT_CLEAR_ENABLE];
    end else if (reg_wr && reg_addr == SBL_ADDR_BREAK_FLAG_CTRL) begin
      clear_enable_r <= reg_wdata[SBL_BIT_CLEAR_ENABLE];
    end
  end

  // read data one cycle after strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SBL_ADDR_BREAK_STATUS: rdata_r <= 8'(exited_wait_r) << SBL_BIT_EXITED_WAIT;
        SBL_ADDR_RESET_CAUSE: rdata_r <= cause_r;
        SBL_ADDR_BREAK_FLAG_CTRL: rdata_r <= 8'(clear_enable_r) << SBL_BIT_CLEAR_ENABLE;
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = rdata_r;

  // checks
  stop_gate_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_STOP |-> !periph_clk_en && !cpu_clk_en) else $error("clocks run in stop");
  wait_clk_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_WAIT |-> !cpu_clk_en && periph_clk_en) else $error("wait clocks wrong");
  wake_stack_a: assert property (@(posedge clk) disable iff (any_rst)
    mode_r == SBL_WAIT && irq_pending && !break_req |=> stack_start) else $error("late stacking");
  short_rec_a: assert property (@(posedge clk) disable iff (any_rst)
    mode_r == SBL_RECOVER && short_stop_recovery && cnt_val == 13'h0000 |-> ##[1:32] stack_start)
    else $error("short recovery late");
  held_cnt_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_STOP |=> cnt_val == 13'h0000) else $error("counter not held");
  mask_clr_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_RUN && stop_exec && !any_rst |-> clear_int_mask ##1 mode_r == SBL_STOP)
    else $error("stop entry wrong");
  read_clear_a: assert property (@(posedge clk) disable iff (any_rst)
    cause_rd && !rst_pin_in == 1'b0 |=> cause_r == 8'h00) else $error("cause not cleared");
  por_flag_a: assert property (@(posedge clk) disable iff (srst)
    power_on_rst |=> cause_r == SBL_RESET_CAUSE_RST) else $error("power-on flag wrong");
  protect_a: assert property (@(posedge clk) disable iff (srst)
    break_r && !clear_enable_r |-> !flag_clear_ok) else $error("flags unprotected");
  wait_brk_a: assert property (@(posedge clk) disable iff (any_rst)
    mode_r == SBL_WAIT && break_req |=> exited_wait_r && mode_r == SBL_RUN) else $error("wait flag");

  // named steps of the low-power sequences
  sequence wait_entry_s;
    mode_r == SBL_RUN && wait_exec && !stop_exec && !any_rst;
  endsequence
  sequence wait_entered_s;
    clear_int_mask ##1 mode_r == SBL_WAIT;
  endsequence
  sequence stop_wake_s;
    mode_r == SBL_STOP && irq_pending && !any_rst;
  endsequence
  sequence long_done_s;
    mode_r == SBL_RECOVER && !short_stop_recovery && cnt_val == 13'h0FFF && !any_rst;
  endsequence
  sequence stack_pulse_s;
    stack_start ##1 !stack_start && mode_r == SBL_RUN;
  endsequence

  // low-power checks
  mask_wait_a: assert property (@(posedge clk) disable iff (srst)
    wait_entry_s |-> wait_entered_s)
    else $error("wait entry wrong");
  stop_wake_a: assert property (@(posedge clk) disable iff (srst)
    stop_wake_s |=> mode_r == SBL_RECOVER && cnt_val == 13'h0000)
    else $error("stop wake wrong");
  long_rec_a: assert property (@(posedge clk) disable iff (any_rst)
    long_done_s |=> stack_pulse_s)
    else $error("long recovery wrong");
  wake_run_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_WAIT && irq_pending && !break_req && !any_rst |=> stack_pulse_s)
    else $error("wait wake wrong");
  stop_rst_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_STOP && any_rst |=> mode_r == SBL_RUN)
    else $error("reset kept stop");
  rec_rst_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_RECOVER && any_rst |=> mode_r == SBL_RUN)
    else $error("reset kept recovery");
  wait_rst_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_WAIT && any_rst |=> mode_r == SBL_RUN)
    else $error("reset kept wait");
  rec_clk_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_RECOVER |-> !cpu_clk_en && !periph_clk_en)
    else $error("clocks run in recovery");
  osc_off_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_STOP && !oscillator_on_in_stop |-> !osc_clk_en)
    else $error("oscillator runs in stop");
  wd_wait_a: assert property (@(posedge clk) disable iff (srst)
    mode_r == SBL_WAIT && !watchdog_disable |-> watchdog_run)
    else $error("watchdog idle in wait");
  wd_off_a: assert property (@(posedge clk) disable iff (srst)
    watchdog_disable |-> !watchdog_run)
    else $error("watchdog runs disabled");

  // break checks
  brk_enter_a: assert property (@(posedge clk) disable iff (srst)
    break_req && !any_rst |=> break_r)
    else $error("break not entered");
  brk_vec_a: assert property (@(posedge clk) disable iff (srst)
    break_req && !break_r |-> force_vector && vector_addr == SBL_SWI_VECTOR)
    else $error("break vector wrong");
  perm_out_a: assert property (@(posedge clk) disable iff (srst)
    !break_r |-> flag_clear_ok)
    else $error("clears blocked outside break");
  perm_en_a: assert property (@(posedge clk) disable iff (srst)
    break_r && clear_enable_r |-> flag_clear_ok)
    else $error("enabled clears blocked");
  brk_rst_a: assert property (@(posedge clk) disable iff (srst)
    any_rst |=> !break_r)
    else $error("break survives reset");

  // reset pin and cause checks
  pin_drive_a: assert property (@(posedge clk) disable iff (srst)
    any_int_rst |=> rst_pin_oe && !rst_pin_out && sys_reset)
    else $error("pin not driven");
  pin_flag_a: assert property (@(posedge clk) disable iff (srst)
    pin_wait_r && hold_r == 3'h0 && cnt_done && mode_r == SBL_RUN && !rst_pin_in && !power_on_rst
    |=> cause_r[SBL_BIT_PIN])
    else $error("pin not recorded");
  wdog_flag_a: assert property (@(posedge clk) disable iff (srst)
    watchdog_rst && !power_on_rst |=> cause_r[SBL_BIT_WATCHDOG]) else $error("watchdog flag");
  illegal_opcode_reset_flag_flag_a: assert property (@(posedge clk) disable iff (srst)
    illegal_op_rst && !power_on_rst |=> cause_r[SBL_BIT_ILL_OP]) else $error("opcode flag");
  illegal_address_reset_flag_flag_a: assert property (@(posedge clk) disable iff (srst)
    illegal_addr_rst && !power_on_rst |=> cause_r[SBL_BIT_ILL_ADDR]) else $error("address flag");
  mon_flag_a: assert property (@(posedge clk) disable iff (srst)
    monitor_rst && !power_on_rst |=> cause_r[SBL_BIT_MONITOR]) else $error("monitor flag");
  lvi_flag_a: assert property (@(posedge clk) disable iff (srst)
    low_volt_rst && !power_on_rst |=> cause_r[SBL_BIT_LOW_VOLT]) else $error("low voltage flag");

  // register read checks
  cause_rd_a: assert property (@(posedge clk) disable iff (srst)
    reg_rd && reg_addr == SBL_ADDR_RESET_CAUSE |=> reg_rdata == $past(cause_r))
    else $error("cause read wrong");
  bsr_rd_a: assert property (@(posedge clk) disable iff (srst)
    reg_rd && reg_addr == SBL_ADDR_BREAK_STATUS |=> reg_rdata[SBL_BIT_EXITED_WAIT] == $past(exited_wait_r))
    else $error("status read wrong");
  rd_idle_a: assert property (@(posedge clk) disable iff (srst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
endmodule : sbl_system_integration_unit

// ---- tb/sbl_periph_model.sv ----
// peripheral status flag with two-step clear, plus reset pin wire
// assumes flag_clear_ok from the unit and a pull-up on the pin
`timescale 1ns/1ps
module sbl_periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // flag events
  input wire logic set_flag,
  input wire logic step_one,
  input wire logic step_two,
  input wire logic flag_clear_ok,
  output logic flag,
  // reset pin
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic ext_low,
  output logic pin
);
  logic armed_r;
  // pull-up unless driven or held low outside
  assign pin = pin_oe ? pin_out : !ext_low;
  always_ff @(posedge clk) begin
    if (srst) begin
      flag <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      if (set_flag) begin
        flag <= 1'b1;
      end
      if (step_one) begin
        armed_r <= 1'b1;
      end else if (step_two && armed_r && flag_clear_ok) begin
        flag <= 1'b0;
        armed_r <= 1'b0;
      end
    end
  end
endmodule : sbl_periph_model

// ---- tb/tb_sbl_system_integration_unit.sv ----
// self-checking bench for the system integration unit
// assumes one 100 ns clock and a peripheral flag model
`timescale 1ns/1ps
module tb_sbl_system_integration_unit;
  import sbl_pkg::*;
  localparam logic [6:0] P_SET = 7'h40, P_S1 = 7'h20, P_S2 = 7'h10, P_WAIT = 7'h08;
  localparam logic [6:0] P_STOP = 7'h04, P_BRK = 7'h02, P_DONE = 7'h01;
  logic clk = 1'b0, srst = 1'b1, ext_low = 1'b0, irq_pending = 1'b0, short_rec = 1'b0, wd_dis = 1'b0;
  logic set_flag = 1'b0, step_one = 1'b0, step_two = 1'b0, wait_exec = 1'b0, stop_exec = 1'b0;
  logic break_req = 1'b0, break_done = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fv, cim;
  logic [5:0] cause = 6'h00;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, rd_v;
  logic [6:0] pat [9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h22, 7'h42};
  logic [7:0] expc [9] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h40, 8'h22, 8'h60};
  logic rst_pin_in, rst_pin_out, rst_pin_oe, clear_int_mask, force_vector, stack_start, in_break;
  logic cpu_clk_en, periph_clk_en, osc_clk_en, watchdog_run, flag_clear_ok, flag, sys_reset;
  logic [15:0] vector_addr;
  logic [7:0] reg_rdata;
  int failures = 0, comparisons = 0, n;
  always #50 clk = ~clk;
  sbl_system_integration_unit sbl_system_integration_unit_i (.clk(clk), .srst(srst),
    .power_on_rst(cause[0]), .watchdog_rst(cause[1]), .illegal_op_rst(cause[2]),
    .illegal_addr_rst(cause[3]), .monitor_rst(cause[4]), .low_volt_rst(cause[5]),
    .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .sys_reset(sys_reset),
    .wait_exec(wait_exec), .stop_exec(stop_exec), .irq_pending(irq_pending), .break_req(break_req),
    .clear_int_mask(clear_int_mask), .force_vector(force_vector), .vector_addr(vector_addr),
    .stack_start(stack_start), .in_break(in_break), .break_done(break_done),
    .short_stop_recovery(short_rec), .watchdog_disable(wd_dis), .oscillator_on_in_stop(1'b0),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_clk_en(osc_clk_en),
    .watchdog_run(watchdog_run), .flag_clear_ok(flag_clear_ok), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sbl_periph_model sbl_periph_model_i (.clk(clk), .srst(srst), .set_flag(set_flag),
    .step_one(step_one), .step_two(step_two), .flag_clear_ok(flag_clear_ok), .flag(flag),
    .pin_oe(rst_pin_oe), .pin_out(rst_pin_out), .ext_low(ext_low), .pin(rst_pin_in));
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [15:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd_v = reg_rdata;
  endtask : rd
  task pulse(input logic [6:0] m);
    @(posedge clk);
    {set_flag, step_one, step_two, wait_exec, stop_exec, break_req, break_done} <= m;
    @(negedge clk);
    fv = force_vector;
    cim = clear_int_mask;
    @(posedge clk);
    {set_flag, step_one, step_two, wait_exec, stop_exec, break_req, break_done} <= 7'h00;
    @(negedge clk);
  endtask : pulse
  task wait_stack(input int lo, input int hi, input string msg);
    @(posedge clk);
    irq_pending <= 1'b1;
    for (n = 0; n < 5000; n++) begin
      @(negedge clk);
      if (stack_start === 1'b1) break;
    end
    @(posedge clk);
    irq_pending <= 1'b0;
    chk(n >= lo && n <= hi, 1'b1, msg);
  endtask : wait_stack
  task t_causes;
    rd(SBL_ADDR_BREAK_STATUS);
    chk(rd_v, SBL_BREAK_STATUS_RST, "status reset");
    rd(16'hFE02);
    chk(rd_v, 8'h00, "unmapped read");
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      {ext_low, cause} <= pat[i];
      repeat (3) @(posedge clk);
      cause <= 6'h00;
      @(negedge clk);
      chk({rst_pin_oe, sys_reset}, {|pat[i][5:0], |pat[i]}, "pin held low");
      repeat (45) @(posedge clk);
      ext_low <= 1'b0;
      repeat (60) @(posedge clk);
      rd(SBL_ADDR_RESET_CAUSE);
      chk(rd_v, expc[i], "reset cause");
    end
    rd(SBL_ADDR_RESET_CAUSE);
    chk(rd_v, 8'h00, "cleared by read");
  endtask : t_causes
  task t_break;
    pulse(P_SET | P_S1);
    pulse(P_BRK);
    chk({fv, vector_addr}, {1'b1, SBL_SWI_VECTOR}, "break vector");
    chk({in_break, flag_clear_ok}, 2'b10, "clears blocked");
    pulse(P_S2);
    chk(flag, 1'b1, "flag protected");
    pulse(P_DONE);
    pulse(P_S2);
    chk(flag, 1'b0, "second step clears");
    pulse(P_SET);
    pulse(P_BRK);
    wr(SBL_ADDR_BREAK_FLAG_CTRL, 8'h80);
    rd(SBL_ADDR_BREAK_FLAG_CTRL);
    chk({rd_v, flag_clear_ok}, 9'h101, "clear enabled");
    pulse(P_S1);
    pulse(P_S2);
    wr(SBL_ADDR_BREAK_FLAG_CTRL, 8'h00);
    pulse(P_DONE);
    chk({flag, flag_clear_ok}, 2'b01, "stays cleared");
  endtask : t_break
  task t_low_power;
    @(posedge clk);
    wd_dis <= 1'b1;
    @(negedge clk);
    chk(watchdog_run, 1'b0, "watchdog disabled");
    @(posedge clk);
    wd_dis <= 1'b0;
    pulse(P_WAIT);
    chk({cim, cpu_clk_en, periph_clk_en, watchdog_run}, 4'hB, "wait entry");
    wait_stack(1, 1, "wait wake");
    pulse(P_WAIT);
    pulse(P_BRK);
    rd(SBL_ADDR_BREAK_STATUS);
    chk(rd_v[SBL_BIT_EXITED_WAIT], 1'b1, "break exits wait");
    pulse(P_DONE);
    wr(SBL_ADDR_BREAK_STATUS, 8'h00);
    rd(SBL_ADDR_BREAK_STATUS);
    chk(rd_v, 8'h00, "exit flag cleared");
    short_rec <= 1'b1;
    pulse(P_STOP);
    chk({cim, cpu_clk_en, periph_clk_en, osc_clk_en}, 4'h8, "stop entry");
    wait_stack(SBL_SHORT_RECOVERY_CYC, SBL_SHORT_RECOVERY_CYC + 2, "short recovery");
    short_rec <= 1'b0;
    pulse(P_STOP);
    wait_stack(SBL_LONG_RECOVERY_CYC, SBL_LONG_RECOVERY_CYC + 2, "long recovery");
  endtask : t_low_power
  task conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_causes();
    t_break();
    t_low_power();
    conclude();
  end
endmodule : tb_sbl_system_integration_unit
